// *** msc_map.vh ***
// Summary of operation
// (RULE_01) management init finishes no later than 2000 ms after power-on, hot plug or reset end.
// (RULE_02) a low level on the module reset line lasting 10 us or more is taken as a reset request.
// (RULE_03) an interrupt condition drives the host interrupt to its asserted level within 200 ms.
// (RULE_04) reading a set flag clears it and the interrupt releases within 500 us of that read.
// (RULE_05) a lane entering loss of signal sets its flag and asserts the interrupt within 100 ms.
// (RULE_06) every flag condition sets its flag and asserts the interrupt unless masked.
// (RULE_07) a mask bit set to one stops its flag from asserting the interrupt.
// (RULE_08) a mask bit cleared to zero lets its flag assert the interrupt again.
// (RULE_09) low-power input, reset input or force-low-power each bring low power within 200 us.
// (RULE_10) the low-power request arrives active low and presence is shown by a pull-down.
// (RULE_11) the interrupt is active high inside the module and seen active low by the host.
// (RULE_12) the host reset arrives active low and is used as an active-low internal reset.
// (RULE_13) management traffic uses the two-wire bus with the host as master and pull-ups; the code uses apb in its place.
// (RULE_14) a flag stays latched until read and sets again if its condition is still present.
// (RULE_15) the interrupt is the or of all latched unmasked flags and drops only when none remain.
`ifndef MSC_MAP_VH
`define MSC_MAP_VH

// register byte offsets
`define MSC_OFF_CTRL 12'h000
`define MSC_OFF_STATUS 12'h004
`define MSC_OFF_FLAG 12'h008
`define MSC_OFF_MASK 12'h00C

// control fields
`define MSC_CTRL_FORCE_LP 0
`define MSC_CTRL_RST_VAL 32'h0000_0000
`define MSC_MASK_RST_VAL 17'h0_0000

// status fields
`define MSC_ST_INIT_DONE 0
`define MSC_ST_LP_MODE 1
`define MSC_ST_RESET_ACT 2
`define MSC_ST_LP_REQ 3
`define MSC_ST_IRQ 4

// flag layout: rx loss of signal, tx fault, init complete
`define MSC_FLAG_W 17
`define MSC_FLAG_LOS_LO 0
`define MSC_FLAG_TXF_LO 8
`define MSC_FLAG_INIT 16
`define MSC_LANES 8

// timing, clock is 40 MHz
`define MSC_CLK_KHZ 40000
`define MSC_INIT_MAX_MS 2000
`define MSC_RESET_MIN_US 10
`define MSC_IRQ_ON_MAX_MS 200
`define MSC_IRQ_OFF_MAX_US 500
`define MSC_LOS_ON_MAX_MS 100
`define MSC_LP_MAX_US 200
// least time: round up to whole cycles
`define MSC_RESET_MIN_CYC ((`MSC_RESET_MIN_US * `MSC_CLK_KHZ + 999) / 1000)
// longest time: round down
`define MSC_INIT_MAX_CYC (`MSC_INIT_MAX_MS * `MSC_CLK_KHZ)

`endif

// *** msc_reset_filter.v ***
`timescale 1ns/1ps
`include "msc_map.vh"

// qualifies the active-low reset line: a request is raised only once the
// line has been low for the minimum pulse time, so glitches are ignored
module msc_reset_filter
(
   input wire clk,
   input wire rst_n,
   input wire line_n,
   output reg req_q
);

   // threshold fits nine bits at the 40 MHz clock; cut to width on purpose
   localparam integer MIN_CYC_I = `MSC_RESET_MIN_CYC;
   localparam [8:0] MIN_CYC = MIN_CYC_I[8:0];

   reg [8:0] cnt_q;

   // count consecutive low cycles, saturate at the threshold
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 9'h000;
         req_q <= 1'b0;
      end
      else if (line_n)
      begin
         cnt_q <= 9'h000;
         req_q <= 1'b0;
      end
      else if (cnt_q != MIN_CYC)
      begin
         cnt_q <= cnt_q + 9'h001;
         req_q <= (cnt_q == MIN_CYC - 9'h001); // RULE_02
      end
   end

endmodule // msc_reset_filter

// *** msc_sideband.v ***
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "msc_map.vh"

// module-side sideband control: init timing, reset and low-power pins,
// latched flags with masks and the module interrupt, registers over apb
module msc_sideband
#(
   parameter [26:0] INIT_CYCLES = `MSC_INIT_MAX_CYC
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire module_reset_in,
   input wire module_lowpower_in,
   input wire [7:0] rx_los,
   input wire [7:0] tx_fault,
   output reg module_irq,
   output reg present_pd_oe,
   output reg lowpower_mode,
   output reg management_init_state,
   output reg module_reset_low
);

   // init sequencer states
   localparam [1:0] ST_RESET = 2'b00;
   localparam [1:0] ST_INIT = 2'b01;
   localparam [1:0] ST_READY = 2'b10;

   localparam [16:0] FLAG_ZERO = 17'h0_0000;

   // address match, used by both the read mux and the write strobes
   function hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [26:0] init_cnt_q;
   reg [26:0] init_cnt_d;
   reg force_lp_q;
   reg [16:0] flag_q;
   reg [16:0] flag_d;
   reg [16:0] mask_q;
   reg init_evt_q;
   reg lp_req_q;
   wire rst_req;
   wire setup;
   wire done;
   wire mapped;
   wire rd_flag;
   wire wr_flag;
   wire wr_ctrl;
   wire wr_mask;
   wire [16:0] set_v;
   wire [16:0] clr_v;
   wire irq_d;
   wire lp_d;
   reg [31:0] rdata_d;

   // host reset pin filtered for the minimum low time
   msc_reset_filter u_rst_filter
   (
      .clk(pclk),
      .rst_n(presetn),
      .line_n(module_reset_in), // RULE_12
      .req_q(rst_req)
   );

   // apb stands in for the two-wire management bus, whose host is the master
   // apb: answer one cycle into the access phase, effects at completion // RULE_13
   assign setup = psel & penable & ~pready;
   assign done = psel & penable & pready;
   assign mapped = hit(paddr, `MSC_OFF_CTRL) | hit(paddr, `MSC_OFF_STATUS) |
                   hit(paddr, `MSC_OFF_FLAG) | hit(paddr, `MSC_OFF_MASK);
   assign rd_flag = done & ~pwrite & hit(paddr, `MSC_OFF_FLAG);
   assign wr_flag = done & pwrite & hit(paddr, `MSC_OFF_FLAG);
   assign wr_ctrl = done & pwrite & hit(paddr, `MSC_OFF_CTRL);
   assign wr_mask = done & pwrite & hit(paddr, `MSC_OFF_MASK);

   // read mux, sampled into prdata when pready is raised
   always @*
   begin
      rdata_d = 32'h0000_0000;
      if (hit(paddr, `MSC_OFF_CTRL))
         rdata_d[`MSC_CTRL_FORCE_LP] = force_lp_q;
      else if (hit(paddr, `MSC_OFF_STATUS))
      begin
         rdata_d[`MSC_ST_INIT_DONE] = management_init_state;
         rdata_d[`MSC_ST_LP_MODE] = lowpower_mode;
         rdata_d[`MSC_ST_RESET_ACT] = (state_q == ST_RESET);
         rdata_d[`MSC_ST_LP_REQ] = lp_req_q;
         rdata_d[`MSC_ST_IRQ] = module_irq;
      end
      else if (hit(paddr, `MSC_OFF_FLAG))
         rdata_d[16:0] = flag_q;
      else if (hit(paddr, `MSC_OFF_MASK))
         rdata_d[16:0] = mask_q;
   end

   // bus response registers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
      else if (setup)
      begin
         pready <= 1'b1;
         pslverr <= ~mapped;
         prdata <= rdata_d;
      end
      else
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // init sequencer: reset held, counting, ready
   always @*
   begin
      state_d = state_q;
      init_cnt_d = init_cnt_q;
      case (state_q)
         ST_RESET:
         begin
            init_cnt_d = 27'h000_0000;
            if (module_reset_in)
               state_d = ST_INIT; // rising edge ends the reset
         end
         ST_INIT:
         begin
            if (rst_req)
               state_d = ST_RESET;
            else if (init_cnt_q >= INIT_CYCLES - 27'h000_0001)
               state_d = ST_READY; // RULE_01
            else
               init_cnt_d = init_cnt_q + 27'h000_0001;
         end
         ST_READY:
         begin
            if (rst_req)
               state_d = ST_RESET;
         end
         default:
         begin
            state_d = ST_RESET;
            init_cnt_d = 27'h000_0000;
         end
      endcase
   end

   // power-on and hot plug both start at the presetn release in init
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_INIT;
         init_cnt_q <= 27'h000_0000;
         init_evt_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         init_cnt_q <= init_cnt_d;
         init_evt_q <= (state_q == ST_INIT) & (state_d == ST_READY);
      end
   end

   // control register, cleared by a module reset as well
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         force_lp_q <= 1'b0;
      else if (state_q == ST_RESET)
         force_lp_q <= 1'b0;
      else if (wr_ctrl)
         force_lp_q <= pwdata[`MSC_CTRL_FORCE_LP];
   end

   // mask register, same layout as the flags
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_q <= `MSC_MASK_RST_VAL;
      else if (state_q == ST_RESET)
         mask_q <= `MSC_MASK_RST_VAL;
      else if (wr_mask)
         mask_q <= pwdata[16:0]; // RULE_07 RULE_08
   end

   // los and fault flag sources are levels: a persisting condition re-sets after a clear; init_evt_q is a one-cycle pulse
   assign set_v = {init_evt_q, tx_fault, rx_los}; // RULE_05 RULE_06 RULE_14
   // clear what the host actually saw on read, or write one to clear;
   // clearing from prdata avoids losing a flag set between sample and end
   assign clr_v = (rd_flag ? prdata[16:0] : FLAG_ZERO) | // RULE_04
                  (wr_flag ? pwdata[16:0] : FLAG_ZERO);

   // set wins over clear so an event in the clearing cycle is kept
   always @*
   begin
      flag_d = (flag_q & ~clr_v) | set_v; // RULE_14
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_q <= FLAG_ZERO;
      else if (state_q == ST_RESET)
         flag_q <= FLAG_ZERO;
      else
         flag_q <= flag_d;
   end

   // interrupt: or of unmasked latched flags, one cycle after the flag
   assign irq_d = |(flag_q & ~mask_q); // RULE_03 RULE_15

   // low-power request arrives active low on the shared pin
   assign lp_d = lp_req_q | (state_q == ST_RESET) | force_lp_q | // RULE_09
                 (state_q != ST_READY);

   // output flops and pin drivers
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         module_irq <= 1'b0;
         present_pd_oe <= 1'b0;
         lowpower_mode <= 1'b1;
         management_init_state <= 1'b0;
         module_reset_low <= 1'b0;
         lp_req_q <= 1'b0;
      end
      else
      begin
         lp_req_q <= ~module_lowpower_in; // RULE_10
         module_irq <= irq_d; // RULE_11
         present_pd_oe <= 1'b1; // RULE_10
         lowpower_mode <= lp_d;
         management_init_state <= (state_q == ST_READY);
         module_reset_low <= (state_q != ST_RESET); // RULE_12
      end
   end

endmodule // msc_sideband

// *** msc_sideband_monitor.sv ***
`timescale 1ns/1ps
`include "msc_map.vh"

// watches the sideband pins; run-length counters stand in for long windows
module msc_sideband_monitor
#(
   parameter [26:0] INIT_CYCLES = 27'h000_0014
)
(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pready,
   input wire module_reset_in,
   input wire module_lowpower_in,
   input wire [7:0] rx_los,
   input wire [7:0] tx_fault,
   input wire module_irq,
   input wire present_pd_oe,
   input wire lowpower_mode,
   input wire management_init_state,
   input wire module_reset_low
);
   localparam int RST_CYC = `MSC_RESET_MIN_CYC;
   logic [31:0] low_cnt_q;
   logic [31:0] wait_cnt_q;
   wire acc_done = psel & penable & pready;
   wire cond_any = |{rx_los, tx_fault};
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // length of the current reset-low run and of the wait for init; short runs only
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_cnt_q <= 32'h0000_0000;
         wait_cnt_q <= 32'h0000_0000;
      end
      else
      begin
         low_cnt_q <= module_reset_in ? 32'h0000_0000 : low_cnt_q + 32'h0000_0001;
         wait_cnt_q <= (!module_reset_in || management_init_state) ? 32'h0000_0000 :
            wait_cnt_q + 32'h0000_0001;
      end
   end
   sequence s_lp_req; !module_lowpower_in [*3]; endsequence
   sequence s_not_ready; !management_init_state [*3]; endsequence
   property p_init_bound; wait_cnt_q <= INIT_CYCLES + 4; endproperty
   property p_rst_long; low_cnt_q >= RST_CYC + 3 |-> !module_reset_low; endproperty
   property p_rst_short; $fell(module_reset_low) |-> low_cnt_q >= RST_CYC - 1; endproperty
   property p_lp_pin; s_lp_req |-> lowpower_mode; endproperty
   property p_lp_init; s_not_ready |-> lowpower_mode; endproperty
   property p_rst_init; !module_reset_low [*2] |-> !management_init_state; endproperty
   property p_present; presetn |=> present_pd_oe; endproperty
   property p_irq_fall;
      $fell(module_irq) |-> $past(acc_done) || $past(acc_done, 2) || $past(acc_done, 3) ||
         !$past(module_reset_low);
   endproperty
   property p_irq_rise;
      $rose(module_irq) |-> $past(cond_any, 2) || $past(cond_any, 3) || $past(acc_done) ||
         $past(acc_done, 2) || $past(acc_done, 3) ||
         ($past(management_init_state) && !$past(management_init_state, 4));
   endproperty
   a_init_bound: assert property (p_init_bound) else $error("init too slow");
   a_rst_long: assert property (p_rst_long) else $error("long reset ignored");
   a_rst_short: assert property (p_rst_short) else $error("short reset taken");
   a_lp_pin: assert property (p_lp_pin) else $error("lp request ignored");
   a_lp_init: assert property (p_lp_init) else $error("high power before init");
   a_rst_init: assert property (p_rst_init) else $error("init done in reset");
   a_present: assert property (p_present) else $error("presence not shown");
   a_irq_fall: assert property (p_irq_fall) else $error("irq dropped alone");
   a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");
endmodule // msc_sideband_monitor

bind msc_sideband msc_sideband_monitor #(.INIT_CYCLES(INIT_CYCLES)) msc_sideband_monitor_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .module_reset_in(module_reset_in), .module_lowpower_in(module_lowpower_in),
   .rx_los(rx_los), .tx_fault(tx_fault), .module_irq(module_irq),
   .present_pd_oe(present_pd_oe), .lowpower_mode(lowpower_mode),
   .management_init_state(management_init_state), .module_reset_low(module_reset_low));

// *** msc_host_model.sv ***
`timescale 1ns/1ps

// host side of the sideband pins; both lines are plain levels the host holds
module msc_host_model
(
   input wire pclk,
   input wire module_irq,
   output logic module_reset_in,
   output logic module_lowpower_in,
   output wire host_irq_low
);
   // idle host: no reset and no low-power request
   initial
   begin
      module_reset_in = 1'b1;
      module_lowpower_in = 1'b1;
   end
   // the host pin shows the interrupt inverted
   assign host_irq_low = ~module_irq;
   // lines change just after an edge and then stay put
   task drive(input logic rst_n, input logic lp_n);
      @(posedge pclk);
      module_reset_in <= rst_n;
      module_lowpower_in <= lp_n;
   endtask
endmodule // msc_host_model

// *** msc_sideband_bench.sv ***
`timescale 1ns/1ps
`include "msc_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
   $display("BAD %s exp %h got %h", nm, e, g); end end

module msc_sideband_bench;
   localparam [26:0] INIT_CYC = 27'h000_0014;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rdat;
   logic [15:0] cond = 16'h0000;
   wire [31:0] prdata;
   wire pready, pslverr, module_irq, present_pd_oe, lowpower_mode, management_init_state;
   wire module_reset_low, module_reset_in, module_lowpower_in, host_irq_low;
   int checked = 0, miscompares = 0, cyc = 0;
   msc_sideband #(.INIT_CYCLES(INIT_CYC)) msc_sideband_i (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .module_reset_in(module_reset_in),
      .module_lowpower_in(module_lowpower_in), .rx_los(cond[7:0]), .tx_fault(cond[15:8]),
      .module_irq(module_irq), .present_pd_oe(present_pd_oe), .lowpower_mode(lowpower_mode),
      .management_init_state(management_init_state), .module_reset_low(module_reset_low));
   msc_host_model msc_host_model_i (.pclk(pclk), .module_irq(module_irq),
      .module_reset_in(module_reset_in), .module_lowpower_in(module_lowpower_in),
      .host_irq_low(host_irq_low));
   // 40 MHz clock
   initial
   begin
      forever #12.5 pclk = ~pclk;
   end
   // a hang ends the run as a failure
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; pready is read before the edge's own updates land
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (n >= 50) miscompares++;
      rdat = prdata;
      rerr = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      `CHK("prdata", e, rdat)
   endtask
   // one-cycle condition pulse, then time for flag and interrupt to follow
   task pulse(input logic [15:0] v);
      cond <= v;
      ticks(1);
      cond <= 16'h0000;
      ticks(3);
   endtask
   task wait_init;
      int n;
      n = 0;
      while (management_init_state !== 1'b1 && n < 200) begin ticks(1); n++; end
      `CHK("init", 1'b1, management_init_state)
   endtask
   // main sequence
   initial
   begin
      ticks(8);
      presetn <= 1'b1;
      wait_init;
      ticks(3);
      `CHK("lp", 1'b0, lowpower_mode)
      `CHK("irq", 1'b1, module_irq)
      `CHK("irq_pin", 1'b0, host_irq_low)
      `CHK("present", 1'b1, present_pd_oe)
      rd(`MSC_OFF_STATUS, 32'h0000_0011);
      rd(`MSC_OFF_FLAG, 32'h0001_0000);
      rd(`MSC_OFF_FLAG, 32'h0000_0000);
      rd(`MSC_OFF_MASK, 32'h0000_0000);
      rd(12'h010, 32'h0000_0000);
      `CHK("err", 1'b1, rerr)
      for (int i = 0; i < 16; i++)
      begin
         pulse(16'h0001 << i);
         `CHK("irq", 1'b1, module_irq)
         rd(`MSC_OFF_FLAG, {16'h0000, 16'h0001 << i});
         ticks(3);
         `CHK("irq", 1'b0, module_irq)
      end
      apb(1'b1, `MSC_OFF_MASK, 32'h0001_FFFF);
      pulse(16'h0008);
      `CHK("irq", 1'b0, module_irq)
      apb(1'b1, `MSC_OFF_MASK, 32'h0000_0000);
      ticks(3);
      `CHK("irq", 1'b1, module_irq)
      cond <= 16'h0002;
      ticks(2);
      rd(`MSC_OFF_FLAG, 32'h0000_000A);
      rd(`MSC_OFF_FLAG, 32'h0000_0002);
      cond <= 16'h0000;
      ticks(2);
      rd(`MSC_OFF_FLAG, 32'h0000_0002);
      rd(`MSC_OFF_FLAG, 32'h0000_0000);
      apb(1'b1, `MSC_OFF_CTRL, 32'h0000_0001);
      ticks(3);
      `CHK("lp", 1'b1, lowpower_mode)
      rd(`MSC_OFF_CTRL, 32'h0000_0001);
      apb(1'b1, `MSC_OFF_CTRL, 32'h0000_0000);
      msc_host_model_i.drive(1'b1, 1'b0);
      ticks(3);
      rd(`MSC_OFF_STATUS, 32'h0000_000B);
      msc_host_model_i.drive(1'b1, 1'b1);
      ticks(3);
      `CHK("lp", 1'b0, lowpower_mode)
      apb(1'b1, `MSC_OFF_MASK, 32'h0000_0005);
      msc_host_model_i.drive(1'b0, 1'b1);
      ticks(100);
      msc_host_model_i.drive(1'b1, 1'b1);
      ticks(3);
      `CHK("rst", 1'b1, module_reset_low)
      rd(`MSC_OFF_MASK, 32'h0000_0005);
      msc_host_model_i.drive(1'b0, 1'b1);
      ticks(410);
      `CHK("rst", 1'b0, module_reset_low)
      `CHK("lp", 1'b1, lowpower_mode)
      msc_host_model_i.drive(1'b1, 1'b1);
      wait_init;
      rd(`MSC_OFF_MASK, 32'h0000_0000);
      tally_and_finish;
   end
endmodule // msc_sideband_bench
